// *** logic/pssel_consts.vh ***
// Constants for the protection switch output selector
`ifndef PSSEL_CONSTS_VH
`define PSSEL_CONSTS_VH
// Switch modes
`define PSSEL_MODE_KEEP_PRI 2'h0
`define PSSEL_MODE_KEEP_STB 2'h1
`define PSSEL_MODE_MANUAL 2'h2
// Input codes
`define PSSEL_IN_PRI 2'h0
`define PSSEL_IN_SEC 2'h1
`define PSSEL_IN_ALT 2'h2
// Output pair source codes
`define PSSEL_SRC_PROG 3'h0
`define PSSEL_SRC_BACKUP 3'h1
`define PSSEL_SRC_PRI 3'h2
`define PSSEL_SRC_SEC 3'h3
`define PSSEL_SRC_ALT 3'h4
// Factory defaults
`define PSSEL_DEF_MODE 2'h0
`define PSSEL_DEF_DELAY 8'h00
`define PSSEL_DEF_BACKUP 2'h1
`define PSSEL_DEF_PAIR_SRC 3'h0
`define PSSEL_DEF_LABEL_PRI 2'h0
`define PSSEL_DEF_LABEL_SEC 2'h1
`define PSSEL_DEF_LABEL_ALT 2'h2
// Delay limits and timing
`define PSSEL_DELAY_MAX 8'hFE
`define PSSEL_CLOCK_HZ 100000000
`define PSSEL_SECOND_NS 1000000000
`define PSSEL_CLOCK_NS 10
`endif

// *** logic/pssel_top.v ***
// Output selector of a three-input video protection switch
// What this block does
// - A force command routes the named input to program regardless of health.
// - The switch mode is always keep-primary, keep-stable or manual.
// - In keep-primary, program returns to primary after the switchback delay.
// - The switchback delay is 0 to 254 whole seconds, used in keep-primary only.
// - In keep-stable, the current primary or secondary input stays while good.
// - In manual, program changes only on a manual switching command.
// - Each of three output pairs selects one of five sources.
// - Pair sources ignore force commands; only program pairs follow.
// - A closed external line takes program selection, sets manual and flags it.
// - While any external line is closed, other program commands are ignored.
// - After external control ends, manual stays and mode selection is accepted.
// - Restore-defaults reloads mode, delay, backup and pair sources, not the labels.
// - Restore-names returns the input labels to their factory labels.
// - The backup candidate is the secondary or the alternate input.
`timescale 1ns/1ps
`default_nettype none
`include "pssel_consts.vh"

module pssel_top #(
  parameter [31:0] SECOND_CYCLES = `PSSEL_SECOND_NS / `PSSEL_CLOCK_NS
) (
  input wire clock,
  input wire rst,
  input wire pri_good,
  input wire sec_good,
  input wire alt_good,
  input wire force_pri,
  input wire force_sec,
  input wire force_alt,
  input wire mode_wr,
  input wire [1:0] mode_in,
  input wire delay_wr,
  input wire [7:0] delay_in,
  input wire backup_wr,
  input wire [1:0] backup_in,
  input wire pair_wr,
  input wire [1:0] pair_idx,
  input wire [2:0] pair_src_in,
  input wire restore_defaults,
  input wire restore_names,
  input wire [3:0] ext_line,
  output reg [1:0] switch_mode,
  output reg [7:0] switch_delay,
  output reg [1:0] backup_sel,
  output reg [1:0] program_sel,
  output reg [1:0] forced_input,
  output reg forced_active,
  output reg ext_control,
  output reg local_remote_disabled,
  output reg [2:0] pair1_src,
  output reg [2:0] pair2_src,
  output reg [2:0] pair3_src,
  output reg [1:0] pair1_input,
  output reg [1:0] pair2_input,
  output reg [1:0] pair3_input,
  output reg [1:0] label_pri,
  output reg [1:0] label_sec,
  output reg [1:0] label_alt,
  output reg switchback_pending
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  reg [6:0] sync1;
  reg [6:0] sync2;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
    end else begin
      sync1 <= {ext_line, alt_good, sec_good, pri_good};
      sync2 <= sync1;
    end
  end
  wire s_pri = sync2[0];
  wire s_sec = sync2[1];
  wire s_alt = sync2[2];
  wire [3:0] s_ext = sync2[6:3];
  wire ext_any = |s_ext;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function in_good;
    input [1:0] sel;
    input p;
    input s;
    input a;
    begin
      case (sel)
        `PSSEL_IN_PRI: in_good = p;
        `PSSEL_IN_SEC: in_good = s;
        `PSSEL_IN_ALT: in_good = a;
        default: in_good = 1'b0;
      endcase
    end
  endfunction

  function [1:0] pair_map;
    input [2:0] src;
    input [1:0] prog;
    input [1:0] bkp;
    begin
      case (src)
        `PSSEL_SRC_PROG: pair_map = prog;
        `PSSEL_SRC_BACKUP: pair_map = bkp;
        `PSSEL_SRC_PRI: pair_map = `PSSEL_IN_PRI;
        `PSSEL_SRC_SEC: pair_map = `PSSEL_IN_SEC;
        `PSSEL_SRC_ALT: pair_map = `PSSEL_IN_ALT;
        default: pair_map = prog;
      endcase
    end
  endfunction

  // Lowest closed line wins: lines 0..2 pick an input, line 3 picks backup
  function [1:0] ext_pick;
    input [3:0] l;
    input [1:0] bkp;
    begin
      if (l[0])
        ext_pick = `PSSEL_IN_PRI;
      else if (l[1])
        ext_pick = `PSSEL_IN_SEC;
      else if (l[2])
        ext_pick = `PSSEL_IN_ALT;
      else
        ext_pick = bkp;
    end
  endfunction

  // ------------------------------------------------------------
  // Second tick divider
  // ------------------------------------------------------------
  reg [31:0] sec_cnt;
  wire sec_tick = (sec_cnt == SECOND_CYCLES - 32'h1);
  always @(posedge clock or posedge rst) begin
    if (rst)
      sec_cnt <= 32'h0;
    else if (!switchback_pending || sec_tick)
      sec_cnt <= 32'h0;
    else
      sec_cnt <= sec_cnt + 32'h1;
  end

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  wire force_any = force_pri | force_sec | force_alt;
  reg [1:0] force_code;
  always @* begin
    if (force_pri)
      force_code = `PSSEL_IN_PRI;
    else if (force_sec)
      force_code = `PSSEL_IN_SEC;
    else
      force_code = `PSSEL_IN_ALT;
  end
  wire mode_ok = (mode_in == `PSSEL_MODE_KEEP_PRI) ||
    (mode_in == `PSSEL_MODE_KEEP_STB) ||
    (mode_in == `PSSEL_MODE_MANUAL);
  wire backup_ok = (backup_in == `PSSEL_IN_SEC) ||
    (backup_in == `PSSEL_IN_ALT);
  wire [7:0] delay_clip = (delay_in > `PSSEL_DELAY_MAX) ?
    `PSSEL_DELAY_MAX : delay_in;
  reg [7:0] delay_left;

  // ------------------------------------------------------------
  // Program selection and mode
  // ------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      switch_mode <= `PSSEL_DEF_MODE;
      switch_delay <= `PSSEL_DEF_DELAY;
      backup_sel <= `PSSEL_DEF_BACKUP;
      program_sel <= `PSSEL_IN_PRI;
      forced_input <= `PSSEL_IN_PRI;
      forced_active <= 1'b0;
      ext_control <= 1'b0;
      local_remote_disabled <= 1'b0;
      switchback_pending <= 1'b0;
      delay_left <= 8'h00;
    end else begin
      ext_control <= ext_any;
      local_remote_disabled <= ext_any;
      if (restore_defaults) begin
        switch_mode <= `PSSEL_DEF_MODE;
        switch_delay <= `PSSEL_DEF_DELAY;
        backup_sel <= `PSSEL_DEF_BACKUP;
        forced_active <= 1'b0;
        switchback_pending <= 1'b0;
      end else begin
        if (delay_wr)
          switch_delay <= delay_clip;
        if (backup_wr && backup_ok)
          backup_sel <= backup_in;
      end
      if (ext_any) begin
        // External lines own program selection
        switch_mode <= `PSSEL_MODE_MANUAL;
        program_sel <= ext_pick(s_ext, backup_sel);
        forced_active <= 1'b0;
        switchback_pending <= 1'b0;
      end else if (!restore_defaults && force_any) begin
        program_sel <= force_code;
        switch_mode <= `PSSEL_MODE_MANUAL;
        forced_input <= force_code;
        forced_active <= 1'b1;
        switchback_pending <= 1'b0;
      end else if (!restore_defaults && mode_wr && mode_ok) begin
        switch_mode <= mode_in;
        forced_active <= (mode_in == `PSSEL_MODE_MANUAL) & forced_active;
        switchback_pending <= 1'b0;
      end else if (!restore_defaults) begin
        case (switch_mode)
          `PSSEL_MODE_KEEP_PRI: begin
            if (program_sel == `PSSEL_IN_PRI) begin
              if (!s_pri && in_good(backup_sel, s_pri, s_sec, s_alt))
                program_sel <= backup_sel;
            end else if (!s_pri) begin
              switchback_pending <= 1'b0;
              if (!in_good(program_sel, s_pri, s_sec, s_alt) &&
                  in_good(backup_sel, s_pri, s_sec, s_alt))
                program_sel <= backup_sel;
            end else if (!switchback_pending) begin
              if (switch_delay == 8'h00) begin
                program_sel <= `PSSEL_IN_PRI;
              end else begin
                switchback_pending <= 1'b1;
                delay_left <= switch_delay;
              end
            end else if (sec_tick) begin
              if (delay_left == 8'h01) begin
                program_sel <= `PSSEL_IN_PRI;
                switchback_pending <= 1'b0;
              end
              delay_left <= delay_left - 8'h01;
            end
          end
          `PSSEL_MODE_KEEP_STB: begin
            if (!in_good(program_sel, s_pri, s_sec, s_alt)) begin
              if (program_sel != `PSSEL_IN_PRI && s_pri)
                program_sel <= `PSSEL_IN_PRI;
              else if (program_sel != `PSSEL_IN_SEC && s_sec)
                program_sel <= `PSSEL_IN_SEC;
              else if (s_alt)
                program_sel <= `PSSEL_IN_ALT;
            end
          end
          `PSSEL_MODE_MANUAL: begin
            program_sel <= program_sel;
          end
          default: switch_mode <= `PSSEL_MODE_MANUAL;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Output pair routing
  // ------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pair1_src <= `PSSEL_DEF_PAIR_SRC;
      pair2_src <= `PSSEL_DEF_PAIR_SRC;
      pair3_src <= `PSSEL_DEF_PAIR_SRC;
    end else if (restore_defaults) begin
      pair1_src <= `PSSEL_DEF_PAIR_SRC;
      pair2_src <= `PSSEL_DEF_PAIR_SRC;
      pair3_src <= `PSSEL_DEF_PAIR_SRC;
    end else if (pair_wr && pair_src_in <= `PSSEL_SRC_ALT) begin
      case (pair_idx)
        2'h0: pair1_src <= pair_src_in;
        2'h1: pair2_src <= pair_src_in;
        2'h2: pair3_src <= pair_src_in;
        default: pair1_src <= pair1_src;
      endcase
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pair1_input <= `PSSEL_IN_PRI;
      pair2_input <= `PSSEL_IN_PRI;
      pair3_input <= `PSSEL_IN_PRI;
    end else begin
      pair1_input <= pair_map(pair1_src, program_sel, backup_sel);
      pair2_input <= pair_map(pair2_src, program_sel, backup_sel);
      pair3_input <= pair_map(pair3_src, program_sel, backup_sel);
    end
  end

  // ------------------------------------------------------------
  // Input labels
  // ------------------------------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      label_pri <= `PSSEL_DEF_LABEL_PRI;
      label_sec <= `PSSEL_DEF_LABEL_SEC;
      label_alt <= `PSSEL_DEF_LABEL_ALT;
    end else if (restore_names) begin
      label_pri <= `PSSEL_DEF_LABEL_PRI;
      label_sec <= `PSSEL_DEF_LABEL_SEC;
      label_alt <= `PSSEL_DEF_LABEL_ALT;
    end
  end

endmodule // pssel_top
`default_nettype wire

// *** sim/pssel_top_checker.sv ***
// Assertion checker for the output selector
`timescale 1ns/1ps
`default_nettype none
module pssel_top_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic force_pri,
  input wire logic force_sec,
  input wire logic force_alt,
  input wire logic mode_wr,
  input wire logic restore_defaults,
  input wire logic [3:0] ext_line,
  input wire logic [1:0] switch_mode,
  input wire logic [7:0] switch_delay,
  input wire logic [1:0] backup_sel,
  input wire logic [1:0] program_sel,
  input wire logic forced_active,
  input wire logic ext_control,
  input wire logic local_remote_disabled,
  input wire logic [2:0] pair1_src,
  input wire logic [1:0] pair1_input
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_mode;
    switch_mode != 2'h3;
  endproperty
  a_mode: assert property (p_mode) else $error("bad mode");
  property p_delay;
    switch_delay <= 8'hFE;
  endproperty
  a_delay: assert property (p_delay) else $error("delay high");
  property p_backup;
    backup_sel == 2'h1 || backup_sel == 2'h2;
  endproperty
  a_backup: assert property (p_backup) else $error("bad backup");
  property p_force;
    force_pri && !restore_defaults && !ext_control && ext_line == 4'h0 &&
    $past(ext_line) == 4'h0 && $past(ext_line, 2) == 4'h0 |=>
    program_sel == 2'h0 && switch_mode == 2'h2 && forced_active;
  endproperty
  a_force: assert property (p_force) else $error("force lost");
  property p_ext;
    (ext_line != 4'h0) [*3] |=>
    ext_control && local_remote_disabled && switch_mode == 2'h2;
  endproperty
  a_ext: assert property (p_ext) else $error("ext not taken");
  property p_lock;
    mode_wr && ext_line != 4'h0 && $past(ext_line) != 4'h0 &&
    $past(ext_line, 2) != 4'h0 |=> switch_mode == 2'h2;
  endproperty
  a_lock: assert property (p_lock) else $error("mode not locked");
  property p_dflt;
    restore_defaults && $past(ext_line, 2) == 4'h0 |=>
    switch_mode == 2'h0 && switch_delay == 8'h00 &&
    backup_sel == 2'h1 && pair1_src == 3'h0;
  endproperty
  a_dflt: assert property (p_dflt) else $error("defaults lost");
  property p_pair;
    pair1_src == 3'h0 && $past(pair1_src) == 3'h0 |->
    pair1_input == $past(program_sel);
  endproperty
  a_pair: assert property (p_pair) else $error("pair lag");
  property p_man;
    switch_mode == 2'h2 && !force_pri && !force_sec && !force_alt &&
    !ext_control && ext_line == 4'h0 && $past(ext_line) == 4'h0 &&
    $past(ext_line, 2) == 4'h0 |=> $stable(program_sel);
  endproperty
  a_man: assert property (p_man) else $error("manual moved");
endmodule // pssel_top_checker
bind pssel_top pssel_top_checker pssel_top_checker_inst (
  .clock(clock), .rst(rst), .force_pri(force_pri),
  .force_sec(force_sec), .force_alt(force_alt), .mode_wr(mode_wr),
  .restore_defaults(restore_defaults), .ext_line(ext_line),
  .switch_mode(switch_mode), .switch_delay(switch_delay),
  .backup_sel(backup_sel), .program_sel(program_sel),
  .forced_active(forced_active), .ext_control(ext_control),
  .local_remote_disabled(local_remote_disabled),
  .pair1_src(pair1_src), .pair1_input(pair1_input)
);
`default_nettype wire

// *** sim/pssel_far_model.sv ***
// Far side model: contact lines and input health
`timescale 1ns/1ps
`default_nettype none
module pssel_far_model (
  input wire logic clock,
  input wire logic [3:0] close_req,
  input wire logic [2:0] good_req,
  output logic [3:0] ext_line,
  output logic [2:0] good
);
  logic [3:0] close_hold;
  logic [2:0] good_hold;
  // Requests are taken on the rising edge, so a change made at a falling
  // edge always lands one cycle later, never racing the bench
  always @(posedge clock) begin
    close_hold <= close_req;
    good_hold <= good_req;
  end
  // Contacts and health move away from the sampling edge
  always @(negedge clock) begin
    ext_line <= close_hold;
    good <= good_hold;
  end
endmodule // pssel_far_model
`default_nettype wire

// *** sim/test_pssel_top.sv ***
// Testbench for the output selector
`timescale 1ns/1ps
`default_nettype none
module test_pssel_top;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic force_pri, force_sec, force_alt, mode_wr, delay_wr, backup_wr;
  logic pair_wr, restore_defaults, restore_names, fa, ec, lrd, pend;
  logic [1:0] mode_in, backup_in, pair_idx, sm, bs, ps, fi, p1i, p2i, p3i;
  logic [1:0] lp, ls, la;
  logic [7:0] delay_in, sd;
  logic [2:0] pair_src_in, good_req, good, p1s, p2s, p3s;
  logic [3:0] close_req, ext_line;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  pssel_far_model pssel_far_model_inst (.clock(clock),
    .close_req(close_req), .good_req(good_req), .ext_line(ext_line),
    .good(good));
  pssel_top #(.SECOND_CYCLES(32'h0000000A)) pssel_top_inst (
    .clock(clock), .rst(rst), .pri_good(good[0]), .sec_good(good[1]),
    .alt_good(good[2]), .force_pri(force_pri), .force_sec(force_sec),
    .force_alt(force_alt), .mode_wr(mode_wr), .mode_in(mode_in),
    .delay_wr(delay_wr), .delay_in(delay_in), .backup_wr(backup_wr),
    .backup_in(backup_in), .pair_wr(pair_wr), .pair_idx(pair_idx),
    .pair_src_in(pair_src_in), .restore_defaults(restore_defaults),
    .restore_names(restore_names), .ext_line(ext_line),
    .switch_mode(sm), .switch_delay(sd), .backup_sel(bs),
    .program_sel(ps), .forced_input(fi), .forced_active(fa),
    .ext_control(ec), .local_remote_disabled(lrd), .pair1_src(p1s),
    .pair2_src(p2s), .pair3_src(p3s), .pair1_input(p1i),
    .pair2_input(p2i), .pair3_input(p3i), .label_pri(lp),
    .label_sec(ls), .label_alt(la), .switchback_pending(pend));
  initial begin
    forever #5 clock = ~clock;
  end
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task cmd(input int k, input logic [7:0] v, input logic [1:0] i);
    @(negedge clock);
    case (k)
      0: force_pri = 1'b1;
      1: force_sec = 1'b1;
      2: force_alt = 1'b1;
      3: {mode_wr, mode_in} = {1'b1, v[1:0]};
      4: {delay_wr, delay_in} = {1'b1, v};
      5: {backup_wr, backup_in} = {1'b1, v[1:0]};
      6: {pair_wr, pair_idx, pair_src_in} = {1'b1, i, v[2:0]};
      7: restore_defaults = 1'b1;
      default: restore_names = 1'b1;
    endcase
    @(negedge clock);
    {force_pri, force_sec, force_alt, mode_wr, delay_wr} = 5'h00;
    {backup_wr, pair_wr, restore_defaults, restore_names} = 4'h0;
  endtask
  task wt(input int k);
    repeat (k) @(negedge clock);
  endtask
  task wait_pend;
    for (n = 0; n < 10 && pend !== 1'b1; n++) @(negedge clock);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test;
    end
  end
  initial begin
    {force_pri, force_sec, force_alt, mode_wr, delay_wr} = 5'h00;
    {backup_wr, pair_wr, restore_defaults, restore_names} = 4'h0;
    {mode_in, backup_in, pair_idx, pair_src_in} = 9'h000;
    delay_in = 8'h00;
    good_req = 3'h7;
    close_req = 4'h0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    chk("reset", 8'h04, {sm, bs, ps});
    $display("test reset done");
    cmd(6, 8'h01, 2'h1);
    cmd(6, 8'h04, 2'h2);
    cmd(6, 8'h05, 2'h2);
    cmd(6, 8'h02, 2'h3);
    chk("pair_src", 16'h000C, {p1s, p2s, p3s});
    good_req = 3'h0;
    for (int k = 0; k < 3; k++) begin
      cmd(k, 8'h00, 2'h0);
      chk("force", {2'h2, 1'b1, k[1:0], k[1:0]}, {sm, fa, fi, ps});
      wt(1);
      chk("pairs", {k[1:0], 2'h1, 2'h2}, {p1i, p2i, p3i});
    end
    cmd(3, 8'h03, 2'h0);
    chk("mode", 8'h02, sm);
    cmd(4, 8'hFF, 2'h0);
    chk("delay", 8'hFE, sd);
    cmd(4, 8'h02, 2'h0);
    cmd(8, 8'h00, 2'h0);
    chk("labels", 8'h24, {la, ls, lp});
    $display("test force done");
    good_req = 3'h7;
    cmd(0, 8'h00, 2'h0);
    cmd(3, 8'h00, 2'h0);
    good_req = 3'h6;
    wt(6);
    chk("failover", 8'h01, ps);
    good_req = 3'h7;
    wait_pend;
    chk("pending", 8'h01, pend);
    wt(10);
    good_req = 3'h6;
    wt(5);
    chk("cancel", 8'h01, {pend, ps});
    good_req = 3'h7;
    wait_pend;
    wt(15);
    chk("restart", 8'h01, ps);
    wt(10);
    chk("switchback", 8'h00, ps);
    $display("test keep primary done");
    cmd(3, 8'h01, 2'h0);
    good_req = 3'h6;
    wt(6);
    good_req = 3'h7;
    wt(30);
    chk("stable", 8'h01, ps);
    $display("test keep stable done");
    close_req = 4'h4;
    wt(5);
    chk("ext", 8'h3A, {ec, lrd, sm, ps});
    cmd(0, 8'h00, 2'h0);
    cmd(3, 8'h00, 2'h0);
    chk("locked", 8'h0A, {sm, ps});
    close_req = 4'h0;
    wt(5);
    chk("released", 8'h02, {ec, sm});
    cmd(3, 8'h01, 2'h0);
    chk("mode", 8'h01, sm);
    $display("test ext lines done");
    cmd(5, 8'h02, 2'h0);
    cmd(5, 8'h03, 2'h0);
    chk("backup", 8'h02, bs);
    cmd(7, 8'h00, 2'h0);
    chk("defaults", 8'h08, {sm, bs, p3s});
    chk("delay", 8'h00, sd);
    $display("test defaults done");
    finish_test;
  end
endmodule // test_pssel_top
`default_nettype wire
